//--- shared/pulse_codec_consts.vh
// Purpose: constants for the isolated pulse line codec
// Assumes: 100 MHz core clock
// Notes:   times in ns, cycle counts derived from the clock period
`ifndef PULSE_CODEC_CONSTS_VH
`define PULSE_CODEC_CONSTS_VH
`define CLK_PERIOD_NS      8'h0A
`define LONG_HALF_NS       8'h96
`define SHORT_HALF_NS      8'h32
`define LONG_HALF_CYC      (`LONG_HALF_NS / `CLK_PERIOD_NS)
`define SHORT_HALF_CYC     (`SHORT_HALF_NS / `CLK_PERIOD_NS)
`define THRESH_CYC         ((`LONG_HALF_CYC + `SHORT_HALF_CYC) / 8'h02)
`define MATCH_TOL_CYC      8'h02
`define MAX_HALF_CYC       (`LONG_HALF_CYC + `MATCH_TOL_CYC)
`define ECHO_HOLD_CYC      3'h6
`define HALF_CNT_W         8
`define SYM_W              2
`define SYM_LONG_POS       2'h0
`define SYM_LONG_NEG       2'h1
`define SYM_SHORT_POS      2'h2
`define SYM_SHORT_NEG      2'h3
`define FIFO_DEPTH         4
`define FIFO_AW            2
`define STRAP_RESET        1'b0
`endif

//--- hw/sym_fifo.v
// Purpose: small symbol FIFO between event capture and pulse transmitter
// Assumes: single clock, synchronous active-high reset
// Notes:   read data is registered; depth is a power of two
`timescale 1ns/1ps
module sym_fifo #(
  parameter WIDTH = 2,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clock_i,
  input  wire             reset_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output reg  [WIDTH-1:0] out_data_o,
  output reg              out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW:0]      wr_ptr_reg;
  reg [AW:0]      rd_ptr_reg;
  wire            empty;
  wire            full;
  wire            push;
  wire            pop;
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                 (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign in_ready_o = !full;
  assign push = in_valid_i && !full;
  // output register refills when empty or consumed
  assign pop = !empty && (!out_valid_o || out_ready_i);
  always @(posedge clock_i) begin
    if (reset_i) begin
      wr_ptr_reg  <= {(AW+1){1'b0}};
      rd_ptr_reg  <= {(AW+1){1'b0}};
      out_valid_o <= 1'b0;
      out_data_o  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        out_data_o  <= mem_reg[rd_ptr_reg[AW-1:0]];
        out_valid_o <= 1'b1;
        rd_ptr_reg  <= rd_ptr_reg + 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
    end
  end
endmodule

//--- hw/pulse_tx.v
// Purpose: doublet pulse transmitter driving the two line drivers
// Assumes: symbols arrive with valid/ready; one symbol at a time
// Notes:   both drivers off between symbols; idle state gives at least a one-cycle gap
`timescale 1ns/1ps
`include "pulse_codec_consts.vh"
module pulse_tx (
  input  wire                   clock_i,
  input  wire                   reset_i,
  input  wire [`SYM_W-1:0]      sym_i,
  input  wire                   sym_valid_i,
  output wire                   sym_ready_o,
  output reg                    src_pos_o,
  output reg                    src_neg_o,
  output reg                    busy_o
);
  localparam S_IDLE   = 3'b001;
  localparam S_FIRST  = 3'b010;
  localparam S_SECOND = 3'b100;
  reg [2:0]             state_reg;
  reg [`HALF_CNT_W-1:0] cnt_reg;
  reg [`HALF_CNT_W-1:0] half_reg;
  reg                   pos_first_reg;
  wire                  take;
  assign sym_ready_o = (state_reg == S_IDLE);
  assign take = sym_valid_i && sym_ready_o;
  // one half width per symbol, equal halves keep dc balance
  function [`HALF_CNT_W-1:0] half_len;
    input [`SYM_W-1:0] s;
    begin
      if (s == `SYM_LONG_POS || s == `SYM_LONG_NEG)
        half_len = `LONG_HALF_CYC;                   // [RULE7]
      else
        half_len = `SHORT_HALF_CYC;                  // [RULE7]
    end
  endfunction
  always @(posedge clock_i) begin
    if (reset_i) begin
      state_reg     <= S_IDLE;
      cnt_reg       <= {`HALF_CNT_W{1'b0}};
      half_reg      <= {`HALF_CNT_W{1'b0}};
      pos_first_reg <= 1'b0;
      src_pos_o     <= 1'b0;
      src_neg_o     <= 1'b0;
      busy_o        <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          src_pos_o <= 1'b0;                         // [RULE4]
          src_neg_o <= 1'b0;
          busy_o    <= 1'b0;
          if (take) begin
            pos_first_reg <= (sym_i == `SYM_LONG_POS) ||
                             (sym_i == `SYM_SHORT_POS);
            half_reg  <= half_len(sym_i);
            cnt_reg   <= half_len(sym_i) - 1'b1;
            src_pos_o <= (sym_i == `SYM_LONG_POS) ||
                         (sym_i == `SYM_SHORT_POS);   // [RULE5]
            src_neg_o <= (sym_i == `SYM_LONG_NEG) ||
                         (sym_i == `SYM_SHORT_NEG);   // [RULE6]
            busy_o    <= 1'b1;
            state_reg <= S_FIRST;
          end
        end
        S_FIRST: begin
          if (cnt_reg == {`HALF_CNT_W{1'b0}}) begin
            // second half reversed, same length
            src_pos_o <= !pos_first_reg;             // [RULE3] [RULE8]
            src_neg_o <= pos_first_reg;
            cnt_reg   <= half_reg - 1'b1;            // [RULE8]
            state_reg <= S_SECOND;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        S_SECOND: begin
          if (cnt_reg == {`HALF_CNT_W{1'b0}}) begin
            src_pos_o <= 1'b0;                       // [RULE5] [RULE6]
            src_neg_o <= 1'b0;
            busy_o    <= 1'b0;
            state_reg <= S_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= S_IDLE;
          src_pos_o <= 1'b0;
          src_neg_o <= 1'b0;
        end
      endcase
    end
  end
endmodule

//--- hw/pulse_line_codec.v
// Purpose: pulse line codec, upstream slave port and downstream master
// Assumes: line comparators deliver digital pos/neg levels; 100 MHz clock
// Notes:   drivers are source/sink enables; the analog side is external
`timescale 1ns/1ps
`include "pulse_codec_consts.vh"
// Summary of operation
// RULE1 - downstream port is always a two-wire pulse master, no 4-wire mode
// RULE2 - upstream port is slave; strap picks two-wire pulses or 4-wire SPI
// RULE3 - transmitter makes positive, negative or off line states only
// RULE4 - drivers off when no pulse is sent, line rests at zero
// RULE5 - plus-one symbol is positive half then equal negative half
// RULE6 - minus-one symbol is negative half then equal positive half
// RULE7 - four symbols; long halves 150 ns, short halves 50 ns
// RULE8 - symbol lasts twice its half width, halves symmetric
// RULE9 - bias reference on only while some pulse port is active
// RULE10 - in 4-wire mode host SPI events are relayed as downstream pulses
// RULE11 - upstream two-wire port tolerates multi-drop shared link
// RULE12 - cs rise long+1, cs fall long-1, clock rise short by data
// RULE13 - slave decodes pulses to cs and data; zero read bit replies short-1
// RULE14 - slave never sends long or plus-one; no reply means one
// RULE15 - receiver classifies by first half polarity and length threshold
// RULE16 - unmatched first half is discarded with no event
module pulse_line_codec (
  input  wire clock_i,
  input  wire reset_i,
  input  wire link_mode_strap_i,
  input  wire spi_cs_n_i,
  input  wire spi_sck_i,
  input  wire spi_sdi_i,
  output reg  spi_sdo_o,
  output reg  spi_sdo_oe_n_o,
  input  wire up_pos_line_i,
  input  wire up_neg_line_i,
  output reg  up_pos_src_o,
  output reg  up_neg_src_o,
  output reg  dn_pos_src_o,
  output reg  dn_neg_src_o,
  output reg  int_chip_select_n_o,
  output reg  int_sdi_o,
  output reg  int_sck_pulse_o,
  input  wire int_sdo_i,
  input  wire int_read_active_i,
  input  wire idle_i,
  output reg  bias_reference_en_o,
  output reg  pulse_mode_o,
  output reg  event_drop_o
);
  localparam R_IDLE  = 3'b001;
  localparam R_FIRST = 3'b010;
  localparam R_SEC   = 3'b100;
  // three-stage synchronisers, the first stage feeds only the second
  reg [2:0]             cs_sync_reg;
  reg [2:0]             sck_sync_reg;
  reg [2:0]             sdi_sync_reg;
  reg [2:0]             up_p_sync_reg;
  reg [2:0]             up_n_sync_reg;
  reg [2:0]             strap_sync_reg;
  reg                   cs_q_reg;
  reg                   sck_q_reg;
  reg                   sdi_q_reg;
  reg                   up_p_q_reg;
  reg                   up_n_q_reg;
  reg                   strap_q_reg;
  reg [2:0]             rx_state_reg;
  reg [`HALF_CNT_W-1:0] first_cnt_reg;
  reg [`HALF_CNT_W-1:0] sec_cnt_reg;
  reg                   first_pos_reg;
  reg                   reply_pending_reg;
  reg [2:0]             echo_hold_reg;
  reg [`SYM_W-1:0]      ev_sym;
  reg                   ev_valid;
  wire                  fifo_ready;
  wire [`SYM_W-1:0]     tx_sym;
  wire                  tx_valid;
  wire                  tx_ready;
  wire                  dn_pos_w;
  wire                  dn_neg_w;
  wire                  dn_busy;
  wire                  up_rep_ready;
  wire                  up_rep_pos;
  wire                  up_rep_neg;
  wire                  up_rep_busy;
  wire                  spi_mode;
  wire                  cs_rise;
  wire                  cs_fall;
  wire                  sck_rise;
  wire                  line_pos;
  wire                  line_neg;
  wire                  is_long_first;
  wire                  sec_ok;
  // a level counts once stages two and three agree
  function filt;
    input [2:0] s;
    input       prev;
    begin
      filt = (s[1] == s[2]) ? s[2] : prev;
    end
  endfunction
  always @(posedge clock_i) begin
    if (reset_i) begin
      cs_sync_reg    <= 3'h7;
      sck_sync_reg   <= 3'h7;
      sdi_sync_reg   <= 3'h0;
      up_p_sync_reg  <= 3'h0;
      up_n_sync_reg  <= 3'h0;
      strap_sync_reg <= 3'h0;
      cs_q_reg       <= 1'b1;
      sck_q_reg      <= 1'b1;
      sdi_q_reg      <= 1'b0;
      up_p_q_reg     <= 1'b0;
      up_n_q_reg     <= 1'b0;
      strap_q_reg    <= `STRAP_RESET;
    end else begin
      cs_sync_reg    <= {cs_sync_reg[1:0], spi_cs_n_i};
      sck_sync_reg   <= {sck_sync_reg[1:0], spi_sck_i};
      sdi_sync_reg   <= {sdi_sync_reg[1:0], spi_sdi_i};
      up_p_sync_reg  <= {up_p_sync_reg[1:0], up_pos_line_i};
      up_n_sync_reg  <= {up_n_sync_reg[1:0], up_neg_line_i};
      strap_sync_reg <= {strap_sync_reg[1:0], link_mode_strap_i};
      cs_q_reg       <= filt(cs_sync_reg, cs_q_reg);
      sck_q_reg      <= filt(sck_sync_reg, sck_q_reg);
      sdi_q_reg      <= filt(sdi_sync_reg, sdi_q_reg);
      up_p_q_reg     <= filt(up_p_sync_reg, up_p_q_reg);
      up_n_q_reg     <= filt(up_n_sync_reg, up_n_q_reg);
      strap_q_reg    <= filt(strap_sync_reg, strap_q_reg);
    end
  end
  // strap low selects 4-wire SPI, high selects two-wire pulses
  assign spi_mode = !strap_q_reg;                     // [RULE2]
  assign cs_fall  = spi_mode && cs_q_reg && !filt(cs_sync_reg, cs_q_reg);
  assign cs_rise  = spi_mode && !cs_q_reg && filt(cs_sync_reg, cs_q_reg);
  assign sck_rise = spi_mode && !cs_q_reg && !sck_q_reg &&
                    filt(sck_sync_reg, sck_q_reg);
  // both lines high at once is not a legal state, treat as neither
  assign line_pos = up_p_q_reg && !up_n_q_reg;
  assign line_neg = up_n_q_reg && !up_p_q_reg;
  assign is_long_first = (first_cnt_reg >= `THRESH_CYC);      // [RULE15]
  assign sec_ok = is_long_first ? (sec_cnt_reg >= `THRESH_CYC)
                                : (sec_cnt_reg <  `THRESH_CYC);
  // spi events into symbols for the downstream master
  always @* begin
    ev_valid = 1'b0;
    ev_sym   = `SYM_LONG_POS;
    if (cs_rise) begin
      ev_valid = 1'b1;
      ev_sym   = `SYM_LONG_POS;                       // [RULE12] [RULE10]
    end else if (cs_fall) begin
      ev_valid = 1'b1;
      ev_sym   = `SYM_LONG_NEG;                       // [RULE12] [RULE10]
    end else if (sck_rise) begin
      ev_valid = 1'b1;
      ev_sym   = filt(sdi_sync_reg, sdi_q_reg) ? `SYM_SHORT_POS
                                               : `SYM_SHORT_NEG; // [RULE12]
    end
  end
  sym_fifo #(
    .WIDTH(`SYM_W),
    .DEPTH(`FIFO_DEPTH),
    .AW   (`FIFO_AW)
  ) u_fifo (
    .clock_i    (clock_i),
    .reset_i    (reset_i),
    .in_data_i  (ev_sym),
    .in_valid_i (ev_valid),
    .in_ready_o (fifo_ready),
    .out_data_o (tx_sym),
    .out_valid_o(tx_valid),
    .out_ready_i(tx_ready)
  );
  // downstream port is always a pulse master
  pulse_tx u_dn_tx (                                  // [RULE1]
    .clock_i    (clock_i),
    .reset_i    (reset_i),
    .sym_i      (tx_sym),
    .sym_valid_i(tx_valid),
    .sym_ready_o(tx_ready),
    .src_pos_o  (dn_pos_w),
    .src_neg_o  (dn_neg_w),
    .busy_o     (dn_busy)
  );
  // upstream reply transmitter only ever gets short minus-one
  pulse_tx u_up_tx (
    .clock_i    (clock_i),
    .reset_i    (reset_i),
    .sym_i      (`SYM_SHORT_NEG),                     // [RULE14]
    .sym_valid_i(reply_pending_reg),
    .sym_ready_o(up_rep_ready),
    .src_pos_o  (up_rep_pos),
    .src_neg_o  (up_rep_neg),
    .busy_o     (up_rep_busy)
  );
  // pulse receiver on the upstream slave port
  always @(posedge clock_i) begin
    if (reset_i) begin
      rx_state_reg        <= R_IDLE;
      first_cnt_reg       <= {`HALF_CNT_W{1'b0}};
      sec_cnt_reg         <= {`HALF_CNT_W{1'b0}};
      first_pos_reg       <= 1'b0;
      int_chip_select_n_o <= 1'b1;
      int_sdi_o           <= 1'b0;
      int_sck_pulse_o     <= 1'b0;
      reply_pending_reg   <= 1'b0;
      echo_hold_reg       <= 3'h0;
      event_drop_o        <= 1'b0;
    end else begin
      int_sck_pulse_o <= 1'b0;
      event_drop_o    <= 1'b0;
      if (reply_pending_reg && up_rep_ready)
        reply_pending_reg <= 1'b0;
      // own reply echo outlasts busy by the synchroniser and output delay
      if (up_rep_busy)
        echo_hold_reg <= `ECHO_HOLD_CYC;
      else if (echo_hold_reg != 3'h0)
        echo_hold_reg <= echo_hold_reg - 3'h1;
      if (spi_mode) begin
        // 4-wire mode: internal port follows the pins directly
        rx_state_reg        <= R_IDLE;
        int_chip_select_n_o <= cs_q_reg;
        int_sdi_o           <= sdi_q_reg;
        int_sck_pulse_o     <= sck_rise;
      end else begin
        case (rx_state_reg)
          R_IDLE: begin
            // own reply echo is ignored while it is on the line
            if ((line_pos || line_neg) && !up_rep_busy &&
                echo_hold_reg == 3'h0) begin
              first_pos_reg <= line_pos;               // [RULE15]
              first_cnt_reg <= {{(`HALF_CNT_W-1){1'b0}}, 1'b1};
              rx_state_reg  <= R_FIRST;
            end
          end
          R_FIRST: begin
            if ((first_pos_reg && line_pos) ||
                (!first_pos_reg && line_neg)) begin
              if (first_cnt_reg >= `MAX_HALF_CYC) begin
                event_drop_o <= 1'b1;                  // [RULE16]
                rx_state_reg <= R_IDLE;
              end else begin
                first_cnt_reg <= first_cnt_reg + 1'b1;
              end
            end else if ((first_pos_reg && line_neg) ||
                         (!first_pos_reg && line_pos)) begin
              sec_cnt_reg  <= {{(`HALF_CNT_W-1){1'b0}}, 1'b1};
              rx_state_reg <= R_SEC;
            end else begin
              event_drop_o <= 1'b1;                    // [RULE16]
              rx_state_reg <= R_IDLE;
            end
          end
          R_SEC: begin
            if ((first_pos_reg && line_neg) ||
                (!first_pos_reg && line_pos)) begin
              if (sec_cnt_reg >= `MAX_HALF_CYC) begin
                event_drop_o <= 1'b1;                  // [RULE16]
                rx_state_reg <= R_IDLE;
              end else begin
                sec_cnt_reg <= sec_cnt_reg + 1'b1;
              end
            end else begin
              rx_state_reg <= R_IDLE;
              if (!sec_ok) begin
                event_drop_o <= 1'b1;                  // [RULE16]
              end else if (is_long_first) begin
                int_chip_select_n_o <= first_pos_reg;  // [RULE13]
              end else begin
                int_sdi_o       <= first_pos_reg;      // [RULE13]
                int_sck_pulse_o <= 1'b1;
                // reply only on zero, silence reads as one
                if (int_read_active_i && !int_sdo_i &&
                    !int_chip_select_n_o)
                  reply_pending_reg <= 1'b1;           // [RULE13] [RULE14]
              end
            end
          end
          default: rx_state_reg <= R_IDLE;
        endcase
      end
    end
  end
  // outputs registered; upstream drivers stay off in 4-wire mode
  always @(posedge clock_i) begin
    if (reset_i) begin
      up_pos_src_o        <= 1'b0;
      up_neg_src_o        <= 1'b0;
      dn_pos_src_o        <= 1'b0;
      dn_neg_src_o        <= 1'b0;
      spi_sdo_o           <= 1'b0;
      spi_sdo_oe_n_o      <= 1'b1;
      bias_reference_en_o <= 1'b0;
      pulse_mode_o        <= 1'b0;
    end else begin
      // multi-drop: drivers off except during own reply
      up_pos_src_o   <= !spi_mode && up_rep_pos;       // [RULE11] [RULE4]
      up_neg_src_o   <= !spi_mode && up_rep_neg;       // [RULE11]
      dn_pos_src_o   <= dn_pos_w;                      // [RULE3]
      dn_neg_src_o   <= dn_neg_w;                      // [RULE3]
      // open drain: drive low only for a zero bit
      spi_sdo_o      <= 1'b0;
      spi_sdo_oe_n_o <= !(spi_mode && !cs_q_reg && !int_sdo_i);
      bias_reference_en_o <= !idle_i;                  // [RULE9]
      pulse_mode_o   <= !spi_mode;
    end
  end
endmodule

//--- verif/codec_checker_monitor.sv
// Purpose: port checks on the pulse line codec
// Assumes: one clock, synchronous active-high reset
// Notes:   helper logic measures how long each downstream driver state lasts
`timescale 1ns/1ps
module codec_checker (
  input wire clock_i,
  input wire reset_i,
  input wire idle_i,
  input wire dn_pos_src_o,
  input wire dn_neg_src_o,
  input wire up_pos_src_o,
  input wire up_neg_src_o,
  input wire int_sck_pulse_o,
  input wire bias_reference_en_o,
  input wire event_drop_o
);
  wire [1:0] st = {dn_pos_src_o, dn_neg_src_o};
  reg  [1:0] prev_reg;
  reg  [7:0] run_reg;
  reg  [7:0] first_reg;
  reg        second_reg;
  // a half ends when a driven state changes to anything else
  wire       edge_w = (st != prev_reg) && (prev_reg != 2'h0);
  always @(posedge clock_i) begin
    if (reset_i) begin
      prev_reg   <= 2'h0;
      run_reg    <= 8'h01;
      first_reg  <= 8'h00;
      second_reg <= 1'b0;
    end else begin
      prev_reg <= st;
      run_reg  <= (st == prev_reg) ? run_reg + 8'h01 : 8'h01;
      if (edge_w && !second_reg && st != 2'h0) begin
        first_reg  <= run_reg;
        second_reg <= 1'b1;
      end else if (st == 2'h0) begin
        second_reg <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  property p_dn_states;
    !(dn_pos_src_o && dn_neg_src_o);
  endproperty
  a_dn_states: assert property (p_dn_states)
    else $error("downstream drivers both on");
  property p_up_states;
    !(up_pos_src_o && up_neg_src_o);
  endproperty
  a_up_states: assert property (p_up_states)
    else $error("upstream drivers both on");
  property p_half_len;
    edge_w |-> (run_reg == 8'h05) || (run_reg == 8'h0F);
  endproperty
  a_half_len: assert property (p_half_len)
    else $error("half pulse of wrong length");
  property p_first_flip;
    edge_w && !second_reg |-> st == ~prev_reg;
  endproperty
  a_first_flip: assert property (p_first_flip)
    else $error("first half not followed by opposite half");
  property p_second_eq;
    edge_w && second_reg |-> st == 2'h0 && run_reg == first_reg;
  endproperty
  a_second_eq: assert property (p_second_eq)
    else $error("second half unequal or line not released");
  property p_bias;
    !$past(reset_i) |-> bias_reference_en_o == !$past(idle_i);
  endproperty
  a_bias: assert property (p_bias)
    else $error("bias enable does not follow idle");
  property p_reply;
    $rose(up_neg_src_o) |-> up_neg_src_o [*5] ##1
      (up_pos_src_o && !up_neg_src_o) [*5] ##1 !up_pos_src_o;
  endproperty
  a_reply: assert property (p_reply)
    else $error("reply is not a short minus one");
  property p_no_pos_first;
    $rose(up_pos_src_o) |-> $past(up_neg_src_o);
  endproperty
  a_no_pos_first: assert property (p_no_pos_first)
    else $error("upstream sent a plus one half first");
  property p_sck_pulse;
    int_sck_pulse_o |=> !int_sck_pulse_o;
  endproperty
  a_sck_pulse: assert property (p_sck_pulse)
    else $error("internal clock pulse longer than one cycle");
  c_long: cover property (edge_w && run_reg == 8'h0F);
  c_short: cover property (edge_w && run_reg == 8'h05);
  c_reply: cover property ($rose(up_neg_src_o));
  c_drop: cover property (event_drop_o);
endmodule
bind pulse_line_codec codec_checker codec_checker_inst (
  .clock_i(clock_i), .reset_i(reset_i), .idle_i(idle_i),
  .dn_pos_src_o(dn_pos_src_o), .dn_neg_src_o(dn_neg_src_o),
  .up_pos_src_o(up_pos_src_o), .up_neg_src_o(up_neg_src_o),
  .int_sck_pulse_o(int_sck_pulse_o),
  .bias_reference_en_o(bias_reference_en_o),
  .event_drop_o(event_drop_o));

//--- verif/pulse_peer.sv
// Purpose: far end of one pulse link, sender and symbol decoder
// Assumes: drivers and comparator levels sampled on the core clock
// Notes:   undriven line rests at zero differential
`timescale 1ns/1ps
module pulse_peer (
  input  wire  clock_i,
  input  wire  pos_src_i,
  input  wire  neg_src_i,
  output logic pos_line_o,
  output logic neg_line_o
);
  logic [1:0] got_q[$];
  logic [1:0] prev_s = 2'h0;
  wire  [1:0] cur_s = {pos_src_i, neg_src_i};
  int         run = 0;
  initial begin
    pos_line_o = 1'b0;
    neg_line_o = 1'b0;
  end
  // code bit 1 marks short, bit 0 a first half that is negative
  always @(posedge clock_i) begin
    if (cur_s == ~prev_s && prev_s != 2'h0)
      got_q.push_back({run < 10, prev_s[0]});
    run    <= (cur_s == prev_s) ? run + 1 : 1;
    prev_s <= cur_s;
  end
  // unequal halves only when a scenario asks for a bad pulse
  task automatic send(input logic plus, input int h1, input int h2);
    repeat (h1) begin
      @(posedge clock_i);
      pos_line_o <= plus;
      neg_line_o <= !plus;
    end
    repeat (h2) begin
      @(posedge clock_i);
      pos_line_o <= !plus;
      neg_line_o <= plus;
    end
    @(posedge clock_i);
    pos_line_o <= 1'b0;
    neg_line_o <= 1'b0;
  endtask
endmodule

//--- verif/testbench.sv
// Purpose: self-checking bench for the pulse line codec
// Assumes: 100 MHz clock, inputs driven by non-blocking at rising edge
// Notes:   symbols on both links are decoded by two peer models
`timescale 1ns/1ps
`include "pulse_codec_consts.vh"
module testbench;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic link_mode_strap_i = 1'b0;
  logic spi_cs_n_i = 1'b1;
  logic spi_sck_i = 1'b1;
  logic spi_sdi_i = 1'b0;
  logic int_sdo_i = 1'b1;
  logic int_read_active_i = 1'b0;
  logic idle_i = 1'b0;
  wire  spi_sdo_o, spi_sdo_oe_n_o, up_pos_line_i, up_neg_line_i;
  wire  up_pos_src_o, up_neg_src_o, dn_pos_src_o, dn_neg_src_o;
  wire  int_chip_select_n_o, int_sdi_o, int_sck_pulse_o;
  wire  bias_reference_en_o, pulse_mode_o, event_drop_o;
  int   bad_count = 0;
  int   total_checks = 0;
  int   cycles = 0;
  int   sck_count = 0;
  int   drop_count = 0;
  pulse_line_codec pulse_line_codec_inst (.*);
  pulse_peer pulse_peer_inst (.clock_i(clock_i),
    .pos_src_i(up_pos_src_o), .neg_src_i(up_neg_src_o),
    .pos_line_o(up_pos_line_i), .neg_line_o(up_neg_line_i));
  // second peer only listens to the downstream drivers
  pulse_peer pulse_peer_dn_inst (.clock_i(clock_i),
    .pos_src_i(dn_pos_src_o), .neg_src_i(dn_neg_src_o),
    .pos_line_o(), .neg_line_o());
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (int_sck_pulse_o === 1'b1) sck_count++;
    if (event_drop_o === 1'b1) drop_count++;
    if (cycles == 5000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  function automatic logic [7:0] pop_dn();
    if (pulse_peer_dn_inst.got_q.size() == 0) return 8'hFF;
    return {6'h00, pulse_peer_dn_inst.got_q.pop_front()};
  endfunction
  task automatic test_reset();
    check("drivers", {up_pos_src_o, up_neg_src_o, dn_pos_src_o,
          dn_neg_src_o}, 8'h00);
    check("cs and oe", {int_chip_select_n_o, spi_sdo_oe_n_o}, 8'h03);
    check("bias", bias_reference_en_o, 8'h00);
  endtask
  // five bits close together queue in the buffer behind a long symbol
  task automatic test_relay();
    logic [4:0] bits;
    bits = 5'b01101;
    check("pulse mode", pulse_mode_o, 8'h00);
    spi_cs_n_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      ticks(5);
      spi_sck_i <= 1'b0;
      spi_sdi_i <= bits[i];
      ticks(4);
      spi_sck_i <= 1'b1;
    end
    ticks(80);
    int_sdo_i <= 1'b0;
    ticks(2);
    check("sdo low", {int_chip_select_n_o, spi_sdo_o, spi_sdo_oe_n_o},
          8'h00);
    int_sdo_i <= 1'b1;
    ticks(2);
    check("sdo off", spi_sdo_oe_n_o, 8'h01);
    spi_cs_n_i <= 1'b1;
    ticks(50);
    check("cs fall", pop_dn(), {6'h00, `SYM_LONG_NEG});
    for (int i = 0; i < 5; i++)
      check("bit", pop_dn(), {6'h01, !bits[i]});
    check("cs rise", pop_dn(), {6'h00, `SYM_LONG_POS});
    check("extra", pop_dn(), 8'hFF);
  endtask
  task automatic test_rx();
    int s0;
    int d0;
    link_mode_strap_i <= 1'b1;
    ticks(10);
    check("pulse mode", pulse_mode_o, 8'h01);
    s0 = sck_count;
    pulse_peer_inst.send(1'b0, 15, 15);
    ticks(8);
    check("cs low", int_chip_select_n_o, 8'h00);
    pulse_peer_inst.send(1'b1, 9, 9);
    ticks(8);
    check("sdi one", int_sdi_o, 8'h01);
    pulse_peer_inst.send(1'b0, 5, 5);
    ticks(8);
    check("sdi zero", int_sdi_o, 8'h00);
    check("clocks", 8'(sck_count - s0), 8'h02);
    int_read_active_i <= 1'b1;
    int_sdo_i <= 1'b0;
    pulse_peer_inst.send(1'b1, 5, 5);
    ticks(25);
    check("reply", {6'h00, pulse_peer_inst.got_q.pop_front()},
          {6'h00, `SYM_SHORT_NEG});
    int_sdo_i <= 1'b1;
    pulse_peer_inst.send(1'b0, 5, 5);
    ticks(25);
    check("no reply", pulse_peer_inst.got_q.size(), 8'h00);
    int_read_active_i <= 1'b0;
    s0 = sck_count;
    d0 = drop_count;
    pulse_peer_inst.send(1'b1, 5, 15);
    ticks(25);
    check("drop", 8'(drop_count - d0), 8'h01);
    pulse_peer_inst.send(1'b0, 5, 0);
    ticks(30);
    check("no clock", 8'(sck_count - s0), 8'h00);
    pulse_peer_inst.send(1'b1, 10, 10);
    ticks(8);
    check("cs high", int_chip_select_n_o, 8'h01);
  endtask
  task automatic test_bias();
    idle_i <= 1'b1;
    ticks(3);
    check("bias idle", bias_reference_en_o, 8'h00);
    idle_i <= 1'b0;
    ticks(3);
    check("bias on", bias_reference_en_o, 8'h01);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    ticks(19);
    test_reset();
    ticks(1);
    reset_i <= 1'b0;
    ticks(10);
    test_relay();
    test_rx();
    test_bias();
    print_verdict();
  end
endmodule
